// ===== src/ppm_defs.vh
// Register offsets, field positions and timing counts of the parallel port
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH

`define PPM_OFS_MODE        4'h0
`define PPM_OFS_ADDR        4'h4
`define PPM_OFS_DATA        4'h8
`define PPM_OFS_STAT        4'hC

`define PPM_F_BUSY          15
`define PPM_F_IRQ_HI        14
`define PPM_F_IRQ_LO        13
`define PPM_F_INC_HI        12
`define PPM_F_INC_LO        11
`define PPM_F_WIDTH         10
`define PPM_F_MODE_HI       9
`define PPM_F_MODE_LO       8
`define PPM_F_SETUP_HI      7
`define PPM_F_SETUP_LO      6
`define PPM_F_STROBE_HI     5
`define PPM_F_STROBE_LO     2
`define PPM_F_END_HI        1
`define PPM_F_END_LO        0

`define PPM_MODE_RESET      15'h0000
`define PPM_ADDR_RESET      16'h0000

`define PPM_PM_LEGACY       2'h0
`define PPM_PM_ENH_SLAVE    2'h1
`define PPM_PM_MASTER2      2'h2
`define PPM_PM_MASTER1      2'h3

`define PPM_IRQ_NONE        2'h0
`define PPM_IRQ_CYCLE       2'h1
`define PPM_IRQ_BUF         2'h2

`define PPM_INC_NONE        2'h0
`define PPM_INC_UP          2'h1
`define PPM_INC_DOWN        2'h2
`define PPM_INC_BUF         2'h3

`define PPM_TPB_DIV         8'h02

`endif

// ===== src/ppm_buf2.v
// Two-entry valid/ready buffer for read data
`timescale 1ns/1ps
module ppm_buf2 #(
	parameter WIDTH = 16
) (
	input  wire             sys_clk_i, // System clock
	input  wire             rst_i,     // Async reset, high
	input  wire             in_valid_i, // Write side valid
	output wire             in_ready_o, // Write side ready
	input  wire [WIDTH-1:0] in_data_i,  // Write side data
	output wire             out_valid_o, // Read side valid
	input  wire             out_ready_i, // Read side ready
	output wire [WIDTH-1:0] out_data_o   // Read side data
);
	reg [WIDTH-1:0] mem [0:1];
	reg             wr_ptr;
	reg             rd_ptr;
	reg [1:0]       count;
	reg [WIDTH-1:0] rd_data;
	wire            push;
	wire            pop;

	assign in_ready_o  = (count != 2'h2);
	assign out_valid_o = (count != 2'h0);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = rd_data;

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push & ~pop)
				count <= count + 2'h1;
			else if (pop & ~push)
				count <= count - 2'h1;
		end
	end

	always @(posedge sys_clk_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	// Registered head so read data comes from a flip-flop
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			rd_data <= {WIDTH{1'b0}};
		else if (pop & (count == 2'h2))
			rd_data <= mem[~rd_ptr];
		else if (push & ((count == 2'h0) | (pop & (count == 2'h1))))
			rd_data <= in_data_i;
	end
endmodule // ppm_buf2

// ===== src/ppm_port.v
// Parallel port with mode register, master strobe engine and slave side
`timescale 1ns/1ps
`include "ppm_defs.vh"

// Overview of operation
// - Busy bit 15 reads 1 during a master transfer, else 0.
// - Interrupt select 01 pulses at each master cycle end and at each slave strobe rise; 00 gives none.
// - Select 10 interrupts on buffer 3 access or slave address 11.
// - Step select 01 increments, 10 decrements, 00 holds the address.
// - Step select 11 auto-steps slave buffer pointers in legacy mode only.
// - Top two address bits used as chip selects never step.
// - Width bit picks one 16-bit or one 8-bit transfer per access.
// - Mode 11 master with direction and enable; 10 separate strobes.
// - Mode 01 enhanced slave with address; 00 legacy slave.
// - Upper eight data pins only take part in 16-bit mode.
// - Setup wait code 00..11 gives one to four bus clocks.
// - Strobe wait zero forces setup 0, end 1 write or 0 read.
// - Upper sixteen bits read zero; fields clear at reset.
module ppm_port #(
	parameter CS_ENABLE = 1'b1
) (
	input  wire        sys_clk_i,  // System clock, 125 MHz
	input  wire        rst_i,      // Async reset, high
	input  wire        wb_cyc_i,   // Wishbone cycle
	input  wire        wb_stb_i,   // Wishbone strobe
	input  wire        wb_we_i,    // Wishbone write
	input  wire [3:0]  wb_adr_i,   // Wishbone byte address
	input  wire [3:0]  wb_sel_i,   // Wishbone byte lanes
	input  wire [31:0] wb_dat_i,   // Wishbone write data
	output reg  [31:0] wb_dat_o,   // Wishbone read data
	output reg         wb_ack_o,   // Wishbone acknowledge
	output reg         irq_o,      // Port event pulse
	output reg  [13:0] port_address_lines_o, // Address pins
	output reg  [1:0]  port_chip_selects_o,  // Chip selects, high active
	output reg         read_strobe_o,  // Master read or direction line
	output reg         write_strobe_o, // Master write strobe
	output reg         enable_strobe_o, // Master enable strobe
	output reg  [15:0] port_data_lines_o,  // Data pins out
	output reg  [15:0] port_data_lines_oe, // Data pins enable
	input  wire [15:0] port_data_lines_i,  // Data pins in
	input  wire        slave_chip_select_in_i, // Slave select, high
	input  wire        slave_read_i,   // Slave read strobe, high
	input  wire        slave_write_i,  // Slave write strobe, high
	input  wire [1:0]  slave_addr_i    // Slave address inputs
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_SETUP = 3'h1;
	localparam ST_STRB  = 3'h2;
	localparam ST_END   = 3'h3;
	localparam ST_DONE  = 3'h4;

	reg [14:0] mode;
	reg [15:0] addr;
	reg [2:0]  state;
	reg [3:0]  wcnt;
	reg        xfer_rd;
	reg [7:0]  div;
	reg        tick;
	reg        rd_push;
	reg [15:0] rd_word;
	reg        rd_pop;
	reg [7:0]  slv_buf [0:3];
	reg [1:0]  slv_ptr;
	reg [2:0]  s_cs;
	reg [2:0]  s_rd;
	reg [2:0]  s_wr;
	reg [1:0]  s_a0;
	reg [1:0]  s_a1;
	reg [1:0]  s_a2;
	reg [15:0] s_d0;
	reg [15:0] s_d1;
	reg [7:0]  slv_out;
	wire       rd_ready;
	wire       rd_valid;
	wire [15:0] rd_data;

	wire [1:0] irq_sel = mode[`PPM_F_IRQ_HI:`PPM_F_IRQ_LO];
	wire [1:0] inc_sel = mode[`PPM_F_INC_HI:`PPM_F_INC_LO];
	wire       wide    = mode[`PPM_F_WIDTH];
	wire [1:0] pmode   = mode[`PPM_F_MODE_HI:`PPM_F_MODE_LO];
	wire [1:0] w_setup = mode[`PPM_F_SETUP_HI:`PPM_F_SETUP_LO];
	wire [3:0] w_strb  = mode[`PPM_F_STROBE_HI:`PPM_F_STROBE_LO];
	wire [1:0] w_end   = mode[`PPM_F_END_HI:`PPM_F_END_LO];
	wire       master  = pmode[1];
	wire       busy    = (state != ST_IDLE);
	wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire       hit_data = req & (wb_adr_i == `PPM_OFS_DATA);
	// A read of the data register drains a word and starts a read; a write starts a write
	wire       start   = hit_data & master & ~busy & (wb_we_i | rd_ready);
	wire       s_rd_rise = s_rd[1] & ~s_rd[2] & s_cs[1];
	wire       s_wr_rise = s_wr[1] & ~s_wr[2] & s_cs[1];

	function [7:0] lane_mask;
		input [3:0] sel;
		input       hi;
		begin
			lane_mask = hi ? {{4{sel[1]}}, {4{sel[1]}}} :
				{{4{sel[0]}}, {4{sel[0]}}};
		end
	endfunction

	function [15:0] step_addr;
		input [15:0] a;
		input [1:0]  inc;
		input        cs;
		reg   [15:0] n;
		begin
			case (inc)
			`PPM_INC_UP:   n = a + 16'h0001;
			`PPM_INC_DOWN: n = a - 16'h0001;
			default:       n = a;
			endcase
			step_addr = cs ? {a[15:14], n[13:0]} : n;
		end
	endfunction

	// Peripheral bus clock enable
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div  <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= (div == `PPM_TPB_DIV - 8'h01);
			div  <= (div == `PPM_TPB_DIV - 8'h01) ? 8'h00 : div + 8'h01;
		end
	end

	// Pin synchronisers; stage 0 feeds stage 1 only
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_cs <= 3'h0;
			s_rd <= 3'h0;
			s_wr <= 3'h0;
			s_a0 <= 2'h0;
			s_a1 <= 2'h0;
			s_a2 <= 2'h0;
			s_d0 <= 16'h0000;
			s_d1 <= 16'h0000;
		end else begin
			s_cs <= {s_cs[1:0], slave_chip_select_in_i};
			s_rd <= {s_rd[1:0], slave_read_i};
			s_wr <= {s_wr[1:0], slave_write_i};
			s_a0 <= slave_addr_i;
			s_a1 <= s_a0;
			s_a2 <= s_a1;
			s_d0 <= port_data_lines_i;
			s_d1 <= s_d0;
		end
	end

	// Register bus, mode and master transfer engine
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode     <= `PPM_MODE_RESET;
			addr     <= `PPM_ADDR_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			state    <= ST_IDLE;
			wcnt     <= 4'h0;
			xfer_rd  <= 1'b0;
			slv_buf[0] <= 8'h00;
			slv_buf[1] <= 8'h00;
			slv_buf[2] <= 8'h00;
			slv_buf[3] <= 8'h00;
			rd_push  <= 1'b0;
			rd_word  <= 16'h0000;
			rd_pop   <= 1'b0;
			irq_o    <= 1'b0;
			slv_ptr  <= 2'h0;
			slv_out  <= 8'h00;
			read_strobe_o   <= 1'b0;
			write_strobe_o  <= 1'b0;
			enable_strobe_o <= 1'b0;
			port_address_lines_o <= 14'h0000;
			port_chip_selects_o  <= 2'h0;
			port_data_lines_o    <= 16'h0000;
			port_data_lines_oe   <= 16'h0000;
		end else begin
			wb_ack_o <= 1'b0;
			rd_push  <= 1'b0;
			rd_pop   <= 1'b0;
			irq_o    <= 1'b0;
			// Data access waits while master is busy or, on a read, while the read buffer is full
			if (req & (~hit_data | ~master | start)) begin
				wb_ack_o <= 1'b1;
				wb_dat_o <= 32'h00000000;
				case (wb_adr_i)
				`PPM_OFS_MODE: begin
					if (wb_we_i) begin
						if (wb_sel_i[0])
							mode[7:0] <= wb_dat_i[7:0];
						if (wb_sel_i[1])
							mode[14:8] <= wb_dat_i[14:8];
					end
					wb_dat_o[15:0] <= {busy, mode};
				end
				`PPM_OFS_ADDR: begin
					if (wb_we_i) begin
						if (wb_sel_i[0])
							addr[7:0] <= wb_dat_i[7:0];
						if (wb_sel_i[1])
							addr[15:8] <= wb_dat_i[15:8];
					end
					wb_dat_o[15:0] <= addr;
				end
				`PPM_OFS_DATA: begin
					if (master & ~wb_we_i) begin
						wb_dat_o[15:0] <= rd_valid ? rd_data : 16'h0000;
						rd_pop <= rd_valid;
					end else if (~master & wb_we_i) begin
						slv_buf[slv_ptr] <= wb_dat_i[7:0];
					end else if (~master) begin
						wb_dat_o[7:0] <= slv_buf[slv_ptr];
					end
				end
				`PPM_OFS_STAT:
					wb_dat_o[15:0] <= {13'h0000, rd_valid, slv_ptr};
				default:
					wb_dat_o <= 32'h00000000;
				endcase
				if (start) begin
					xfer_rd <= ~wb_we_i;
					state   <= ST_SETUP;
					wcnt <= (w_strb == 4'h0) ? 4'h0 : {2'h0, w_setup};
					port_address_lines_o <= addr[13:0];
					port_chip_selects_o <= CS_ENABLE ? addr[15:14] : 2'h0;
					read_strobe_o <= (pmode == `PPM_PM_MASTER1) & ~wb_we_i;
					if (wb_we_i) begin
						port_data_lines_o  <= {
							wb_dat_i[15:8] & lane_mask(wb_sel_i, 1'b1),
							wb_dat_i[7:0] & lane_mask(wb_sel_i, 1'b0)};
						port_data_lines_oe <= wide ? 16'hFFFF : 16'h00FF;
					end
				end
			end
			if (tick) begin
				case (state)
				// Idle must not fall to default: it would cancel a start
				ST_IDLE: begin
				end
				ST_SETUP: begin
					if (wcnt == 4'h0) begin
						state <= ST_STRB;
						wcnt  <= w_strb;
						if (pmode == `PPM_PM_MASTER1)
							enable_strobe_o <= 1'b1;
						else if (xfer_rd)
							read_strobe_o <= 1'b1;
						else
							write_strobe_o <= 1'b1;
					end else
						wcnt <= wcnt - 4'h1;
				end
				ST_STRB: begin
					if (wcnt == 4'h0) begin
						enable_strobe_o <= 1'b0;
						write_strobe_o  <= 1'b0;
						if (pmode != `PPM_PM_MASTER1)
							read_strobe_o <= 1'b0;
						rd_word <= wide ? s_d1 : {8'h00, s_d1[7:0]};
						state   <= ST_END;
						// end forced 1 write, 0 read
						wcnt <= (w_strb == 4'h0) ?
							(xfer_rd ? 4'h0 : 4'h1) : {2'h0, w_end};
					end else
						wcnt <= wcnt - 4'h1;
				end
				ST_END: begin
					if (wcnt == 4'h0) begin
						state              <= ST_DONE;
						port_data_lines_oe <= 16'h0000;
						read_strobe_o      <= 1'b0;
						rd_push            <= xfer_rd;
						addr <= step_addr(addr, inc_sel, CS_ENABLE);
						irq_o <= (irq_sel == `PPM_IRQ_CYCLE);
					end else
						wcnt <= wcnt - 4'h1;
				end
				ST_DONE:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
				endcase
			end
			if (~master & (s_rd_rise | s_wr_rise)) begin
				if (s_wr_rise)
					slv_buf[(pmode == `PPM_PM_ENH_SLAVE) ? s_a1 : slv_ptr]
						<= s_d1[7:0];
				slv_out <= slv_buf[(pmode == `PPM_PM_ENH_SLAVE) ?
					s_a1 : slv_ptr];
				if ((pmode == `PPM_PM_LEGACY) & (inc_sel == `PPM_INC_BUF))
					slv_ptr <= slv_ptr + 2'h1;
				if (irq_sel == `PPM_IRQ_BUF)
					irq_o <= (pmode == `PPM_PM_ENH_SLAVE) ?
						(s_a1 == 2'h3) : (slv_ptr == 2'h3);
				else
					irq_o <= (irq_sel == `PPM_IRQ_CYCLE);
			end
			if (~master & s_cs[1] & s_rd[1]) begin
				port_data_lines_o  <= {8'h00, slv_out};
				port_data_lines_oe <= 16'h00FF;
			end else if (~master)
				port_data_lines_oe <= 16'h0000;
		end
	end

	ppm_buf2 #(
		.WIDTH(16)
	) u_rdbuf (
		.sys_clk_i  (sys_clk_i),
		.rst_i      (rst_i),
		.in_valid_i (rd_push),
		.in_ready_o (rd_ready),
		.in_data_i  (rd_word),
		.out_valid_o(rd_valid),
		.out_ready_i(rd_pop),
		.out_data_o (rd_data)
	);
endmodule // ppm_port

// ===== verif/ppm_port_asserts.sv
// Concurrent checks on the parallel port pins and register bus
`timescale 1ns/1ps
module ppm_port_asserts (
	input logic        sys_clk_i,       // Clock
	input logic        rst_i,           // Reset, high
	input logic        wb_we_i,         // Bus write
	input logic [3:0]  wb_adr_i,        // Bus address
	input logic [31:0] wb_dat_o,        // Bus read data
	input logic        wb_ack_o,        // Bus acknowledge
	input logic        irq_o,           // Event pulse
	input logic [13:0] port_address_lines_o, // Address pins
	input logic        read_strobe_o,   // Read strobe
	input logic        write_strobe_o,  // Write strobe
	input logic        enable_strobe_o, // Enable strobe
	input logic [15:0] port_data_lines_o,  // Data out
	input logic [15:0] port_data_lines_oe  // Data enable
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire stb     = write_strobe_o | enable_strobe_o;
	wire mode_rd = wb_ack_o & ~wb_we_i & (wb_adr_i == 4'h0);
	sequence s_start;
		$rose(stb);
	endsequence
	sequence s_hold;
		stb [*2];
	endsequence
	// Write or enable strobe lasts one tick or more
	a_strobe_min_len: assert property (s_start |-> s_hold)
		else $error("strobe shorter than one tick");
	a_data_held: assert property (stb && $past(stb) |->
		$stable(port_data_lines_o)) else $error("data moved in strobe");
	a_addr_held: assert property (stb && $past(stb) |->
		$stable(port_address_lines_o)) else $error("address moved");
	a_strobes_apart: assert property (!(write_strobe_o &&
		(read_strobe_o || enable_strobe_o))) else $error("strobe clash");
	a_upper_pins: assert property (|port_data_lines_oe[15:8] |->
		&port_data_lines_oe[7:0]) else $error("upper pins alone");
	a_mode_hi_zero: assert property (mode_rd |->
		wb_dat_o[31:16] == 16'h0000) else $error("upper bits set");
	a_busy_flag: assert property (mode_rd && $past(stb) |->
		wb_dat_o[15]) else $error("busy low in transfer");
	a_irq_after_cycle: assert property (irq_o |-> !stb ##1 !irq_o)
		else $error("event pulse misplaced");
endmodule // ppm_port_asserts

bind ppm_port ppm_port_asserts u_chk (.sys_clk_i, .rst_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .irq_o, .port_address_lines_o,
	.read_strobe_o, .write_strobe_o, .enable_strobe_o,
	.port_data_lines_o, .port_data_lines_oe);

// ===== verif/ppm_peer.sv
// Far-side peripheral that answers master read strobes
`timescale 1ns/1ps
module ppm_peer (
	input  logic        sys_clk_i,     // Clock
	input  logic        read_strobe_i, // Read request
	output logic [15:0] data_o         // Data driven to the port
);
	logic [15:0] rd_word = 16'hC3A0;
	logic [15:0] last    = 16'h0000;
	logic        was     = 1'b0;
	// read strobe answer
	// Released lines show the inverse so stale data never passes
	assign data_o = read_strobe_i ? rd_word : ~last;
	always @(posedge sys_clk_i) begin
		if (read_strobe_i)
			last <= rd_word;
		was  <= read_strobe_i;
		if (was && !read_strobe_i)
			rd_word <= rd_word + 16'h0001;
	end
endmodule // ppm_peer

// ===== verif/ppm_port_tb.sv
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
module ppm_port_tb;
	typedef struct {
		logic [31:0] mode;
		logic [15:0] addr;
		logic [15:0] nxt;
		logic [15:0] pins;
		logic [15:0] oe;
		logic [31:0] strb;
		logic [31:0] irqs;
		logic [31:0] pre;
		logic [3:0]  sel;
	} ppm_row_t;
	logic        sys_clk_i;
	logic        rst_i;
	logic        cyc;
	logic        we;
	logic [3:0]  adr;
	logic [31:0] wdat;
	logic [31:0] wbo;
	logic [31:0] rd;
	logic        ack;
	logic        irq;
	logic [13:0] pa;
	logic [1:0]  cs;
	logic        rs;
	logic        ws;
	logic        es;
	logic [15:0] pd;
	logic [15:0] poe;
	logic [15:0] peer_d;
	logic [31:0] cap;
	logic [15:0] cap_a;
	logic [3:0]  sel;
	logic        scs;
	logic        srd;
	logic        swr;
	logic [1:0]  sadr;
	logic [15:0] host_d;
	logic [7:0]  hrd;
	logic        got_stb = 1'b0;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          strobe_n = 0;
	int          irq_n = 0;
	int          setup_n = 0;
	wire  [15:0] pin = (pd & poe) | ((scs ? host_d : peer_d) & ~poe);
	ppm_row_t rows [4] = '{
		'{32'hFFFF2E04, 16'h7FFF, 16'h4000, 16'hA55A, 16'hFFFF,
			4, 1, 1, 4'h3},
		'{32'h000013C9, 16'h8000, 16'hBFFF, 16'h005A, 16'h00FF,
			6, 0, 4, 4'h3},
		'{32'h000002C3, 16'h1234, 16'h1234, 16'h005A, 16'h00FF,
			2, 0, 1, 4'h3},
		'{32'h00000F04, 16'hFFFF, 16'hC000, 16'h005A, 16'hFFFF,
			4, 0, 1, 4'h1}};

	ppm_port #(.CS_ENABLE(1'b1)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wbo), .wb_ack_o(ack),
		.irq_o(irq), .port_address_lines_o(pa), .port_chip_selects_o(cs),
		.read_strobe_o(rs), .write_strobe_o(ws), .enable_strobe_o(es),
		.port_data_lines_o(pd), .port_data_lines_oe(poe),
		.port_data_lines_i(pin), .slave_chip_select_in_i(scs),
		.slave_read_i(srd), .slave_write_i(swr), .slave_addr_i(sadr));
	ppm_peer u_peer (.sys_clk_i(sys_clk_i), .read_strobe_i(rs),
		.data_o(peer_d));

	always @(posedge sys_clk_i) begin
		if (ws | es) begin
			strobe_n <= strobe_n + 1;
			cap      <= {poe, pd & poe};
			cap_a    <= {cs, pa};
		end
		if (irq === 1'b1)
			irq_n <= irq_n + 1;
		// Setup cycles: data driven while no strobe yet in this transfer
		if (poe == 16'h0000)
			got_stb <= 1'b0;
		else if (ws | es)
			got_stb <= 1'b1;
		else if (!got_stb)
			setup_n <= setup_n + 1;
	end

	task print_verdict;
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Holds the request until ack is sampled, then releases it
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (ack !== 1'b1 && n < 500);
		if (ack !== 1'b1) begin
			miscompares++;
			print_verdict();
		end
		rd = wbo;
		cyc <= 1'b0;
		we  <= 1'b0;
	endtask

	task automatic idle(output logic [31:0] first);
		int n;
		wb(1'b0, 4'h0, 32'h0);
		first = rd;
		for (n = 0; rd[15] !== 1'b0 && n < 200; n++)
			wb(1'b0, 4'h0, 32'h0);
		if (rd[15] !== 1'b0) begin
			miscompares++;
			print_verdict();
		end
	endtask

	// Far-side host access through the synchronised slave pins
	task automatic host(input logic w, input logic [1:0] a,
		input logic [7:0] d);
		@(posedge sys_clk_i);
		scs    <= 1'b1;
		swr    <= w;
		srd    <= ~w;
		sadr   <= a;
		host_d <= {8'h00, d};
		repeat (8) @(posedge sys_clk_i);
		hrd = pin[7:0];
		scs <= 1'b0;
		swr <= 1'b0;
		srd <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
	endtask

	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		int          s;
		int          q;
		int          i;
		int          u;
		logic [31:0] b;
		rst_i = 1'b1;
		cyc   = 1'b0;
		we    = 1'b0;
		adr   = 4'h0;
		wdat  = 32'h0;
		sel   = 4'h3;
		scs   = 1'b0;
		srd   = 1'b0;
		swr   = 1'b0;
		sadr  = 2'h0;
		host_d = 16'h0000;
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 4'h0, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, 4'h4, 32'h0);
		check(rd, 32'h0);
		// Unmapped offset answers with zero
		wb(1'b0, 4'h2, 32'h0);
		check(rd, 32'h0);
		for (i = 0; i < 4; i++) begin
			s = strobe_n;
			q = irq_n;
			u = setup_n;
			wb(1'b1, 4'h0, rows[i].mode);
			wb(1'b1, 4'h4, {16'h0000, rows[i].addr});
			sel <= rows[i].sel;
			wb(1'b1, 4'h8, 32'h0000A55A);
			sel <= 4'h3;
			idle(b);
			check(b[15], 1'b1);
			check(32'(strobe_n - s), rows[i].strb);
			check(cap[31:16], rows[i].oe);
			check(cap[15:0], rows[i].pins);
			check(cap_a, rows[i].addr);
			check(32'(irq_n - q), rows[i].irqs);
			check(32'((setup_n - u + 1) / 2), rows[i].pre);
			wb(1'b0, 4'h4, 32'h0);
			check(rd, rows[i].nxt);
			wb(1'b0, 4'h0, 32'h0);
			check(rd, rows[i].mode & 32'h00007FFF);
		end
		// Long strobe covers the two-flop input delay
		wb(1'b1, 4'h0, 32'h0000060C);
		wb(1'b0, 4'h8, 32'h0);
		for (i = 0; i < 2; i++) begin
			idle(b);
			wb(1'b0, 4'h8, 32'h0);
			check(rd[15:0], 16'hC3A0 + i);
		end
		idle(b);
		// Enhanced slave: the host picks buffers by its address pins
		wb(1'b1, 4'h0, 32'h00004100);
		q = irq_n;
		host(1'b1, 2'h3, 8'h5C);
		wb(1'b1, 4'h8, 32'h000000A7);
		host(1'b0, 2'h3, 8'h00);
		check(hrd, 8'h5C);
		host(1'b0, 2'h0, 8'h00);
		check(hrd, 8'hA7);
		check(32'(irq_n - q), 2);
		// Legacy slave steps its pointer; the fourth buffer raises the event
		wb(1'b1, 4'h0, 32'h00005800);
		q = irq_n;
		for (i = 0; i < 3; i++)
			host(1'b1, 2'h0, 8'(i + 16));
		wb(1'b0, 4'hC, 32'h0);
		check(rd[1:0], 2'h3);
		host(1'b1, 2'h0, 8'h13);
		check(32'(irq_n - q), 1);
		wb(1'b0, 4'h8, 32'h0);
		check(rd, 32'h00000010);
		// Reset in mid-run clears every field again
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 4'h0, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, 4'hC, 32'h0);
		check(rd, 32'h0);
		print_verdict();
	end
endmodule // ppm_port_tb
